// >>> pkg/tif_pkg.sv
package tif_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_EN_CLR = 8'h24;
  localparam logic [7:0] OFF_EN_SET = 8'h28;
  localparam logic [7:0] OFF_FLAGS = 8'h2c;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  // Implemented bits; everything else is reserved and reads zero
  localparam logic [31:0] IMPL_MASK = 32'h000f_f80f;

  // ---------------------------------------------------------------
  // Bit positions, shared by enable bank and flags
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int CH_LSB = 16;
  localparam int BIT_UFAULT1 = 15;
  localparam int BIT_UFAULT0 = 14;
  localparam int BIT_RFAULT_B = 13;
  localparam int BIT_RFAULT_A = 12;
  localparam int BIT_DEBUG = 11;
  localparam int BIT_CAP_ERR = 3;
  localparam int BIT_COUNTER = 2;
  localparam int BIT_RESTART = 1;
  localparam int BIT_WRAP = 0;

endpackage : tif_pkg

// >>> src/tif_rst_sync.sv
module tif_rst_sync
  import tif_pkg::*;
(
  // Clock and raw reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Synchronised reset
  output logic rst_n_out
);

  typedef struct packed {
    logic meta;
    logic sync;
  } tif_rs_st_t;

  tif_rs_st_t st_q;
  tif_rs_st_t st_d;

  // ---------------------------------------------------------------
  // Two-stage release; assertion stays asynchronous
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d.meta = 1'b1;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rst_n_out = st_q.sync;

endmodule : tif_rst_sync

// >>> src/tif_flag_cell.sv
module tif_flag_cell
  import tif_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Event timing and control
  input wire logic cond_in,
  input wire logic tick_in,
  input wire logic clr_in,
  // Flag state
  output logic set_out,
  output logic flag_out
);

  typedef struct packed {
    logic pend;
    logic flag;
  } tif_fc_st_t;

  tif_fc_st_t st_q;
  tif_fc_st_t st_d;

  // ---------------------------------------------------------------
  // Condition waits for the next counter clock tick
  // ---------------------------------------------------------------
  always_comb
  begin
    set_out = st_q.pend & tick_in;
    // A condition seen with a tick is held for the following tick
    st_d.pend = cond_in | (st_q.pend & ~tick_in);
    // Set beats clear so that no event is dropped
    st_d.flag = set_out | (st_q.flag & ~clr_in); // RULE_18
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign flag_out = st_q.flag;

  a_flag_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cond_in && !tick_in) |=> !st_q.flag || $past(st_q.flag)) // RULE_08
    else $error("flag set without a counter tick");

  a_flag_tick: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.pend && tick_in) |=>
      st_q.flag && (st_q.pend == $past(cond_in))) // RULE_15
    else $error("flag not set on the counter tick");

endmodule : tif_flag_cell

// >>> src/tif_irq_top.sv
// Operation
// RULE_01 - Set-view one bits enable channel interrupts
// RULE_02 - Set and clear views share one bank
// RULE_03 - Clear-view bit 0 one disables wrap
// RULE_04 - Set-view bits 15..11 enable fault interrupts
// RULE_05 - Set-view bits 3..0 enable low events
// RULE_06 - Reserved bits always read zero
// RULE_07 - Software writes reserved bits as zero
// RULE_08 - Channel flag sets one tick after event
// RULE_09 - Capture-mode value read clears channel flag
// RULE_10 - Writing one clears channel flag
// RULE_11 - Unrecoverable fault flags: tick delay, W1C
// RULE_12 - Recoverable fault flags set one tick later
// RULE_13 - Writing one clears recoverable fault flag
// RULE_14 - Capture onto set channel flag raises error
// RULE_15 - Wrap, counter, restart flags: tick, W1C
// RULE_16 - Debug fault flag: tick delay, W1C
// RULE_17 - Interrupt high while enabled flag set
// RULE_18 - Hardware set beats software clear
module tif_irq_top
  import tif_pkg::*;
#(
  parameter int CH_COUNT = NUM_CH
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Counter clock timing
  input wire logic cnt_tick_in,
  // Channel events
  input wire logic [CH_COUNT-1:0] match_in,
  input wire logic [CH_COUNT-1:0] capture_in,
  input wire logic [CH_COUNT-1:0] capture_mode_in,
  input wire logic [CH_COUNT-1:0] value_read_in,
  // Fault events
  input wire logic ufault1_in,
  input wire logic ufault0_in,
  input wire logic rfault_b_in,
  input wire logic rfault_a_in,
  input wire logic debug_fault_in,
  // Counter events
  input wire logic counter_event_in,
  input wire logic restart_event_in,
  input wire logic wrap_event_in,
  // Interrupt request
  output logic irq_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] en;
    logic [31:0] rdata;
    logic irq;
  } tif_top_st_t;

  tif_top_st_t st_q;
  tif_top_st_t st_d;

  logic rst_n;
  logic [31:0] cond_vec;
  logic [31:0] clr_vec;
  logic [31:0] flag_vec;
  logic [31:0] set_vec;
  logic wr_set;
  logic wr_clr;
  logic wr_flags;

  tif_rst_sync u_rst_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .rst_n_out(rst_n)
  );

  // ---------------------------------------------------------------
  // Event conditions and clears
  // ---------------------------------------------------------------
  assign wr_set = wr_in && (addr_in == OFF_EN_SET);
  assign wr_clr = wr_in && (addr_in == OFF_EN_CLR);
  assign wr_flags = wr_in && (addr_in == OFF_FLAGS);

  always_comb
  begin
    cond_vec = '0;
    // Match or newly captured value
    cond_vec[CH_LSB +: CH_COUNT] = match_in | capture_in; // RULE_08
    cond_vec[BIT_UFAULT1] = ufault1_in; // RULE_11
    cond_vec[BIT_UFAULT0] = ufault0_in; // RULE_11
    cond_vec[BIT_RFAULT_B] = rfault_b_in; // RULE_12
    cond_vec[BIT_RFAULT_A] = rfault_a_in; // RULE_12
    cond_vec[BIT_DEBUG] = debug_fault_in; // RULE_16
    // A capture has nowhere to go while its flag is still up
    cond_vec[BIT_CAP_ERR] =
      |(capture_in & flag_vec[CH_LSB +: CH_COUNT]); // RULE_14
    cond_vec[BIT_COUNTER] = counter_event_in; // RULE_15
    cond_vec[BIT_RESTART] = restart_event_in; // RULE_15
    cond_vec[BIT_WRAP] = wrap_event_in; // RULE_15
  end

  always_comb
  begin
    clr_vec = '0;
    if (wr_flags)
      clr_vec = wdata_in & IMPL_MASK; // RULE_10 RULE_11 RULE_13 RULE_16
    // Value read in capture mode frees the channel
    clr_vec[CH_LSB +: CH_COUNT] = clr_vec[CH_LSB +: CH_COUNT] |
      (value_read_in & capture_mode_in); // RULE_09
  end

  // ---------------------------------------------------------------
  // One flag cell per implemented bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_flag
      if (IMPL_MASK[gi])
      begin : g_cell
        tif_flag_cell u_cell (
          .clk_in(clk_in),
          .rst_n_in(rst_n),
          .cond_in(cond_vec[gi]),
          .tick_in(cnt_tick_in),
          .clr_in(clr_vec[gi]),
          .set_out(set_vec[gi]),
          .flag_out(flag_vec[gi])
        );
      end
      else
      begin : g_rsvd
        // Reserved positions carry no state
        assign set_vec[gi] = 1'b0; // RULE_06
        assign flag_vec[gi] = 1'b0; // RULE_06
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Enable bank, read data, interrupt
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    // Both views act on the same bank
    if (wr_set)
      st_d.en = st_q.en | (wdata_in & IMPL_MASK); // RULE_01 RULE_04 RULE_05
    if (wr_clr)
      st_d.en = st_q.en & ~(wdata_in & IMPL_MASK); // RULE_02 RULE_03
    // Unmapped reads return zero; read data lasts one cycle only
    st_d.rdata = '0;
    if (rd_in)
    begin
      case (addr_in)
        OFF_EN_SET: st_d.rdata = st_q.en & IMPL_MASK; // RULE_02 RULE_06
        OFF_EN_CLR: st_d.rdata = st_q.en & IMPL_MASK; // RULE_02 RULE_06
        OFF_FLAGS: st_d.rdata = flag_vec & IMPL_MASK; // RULE_06
        default: st_d.rdata = '0;
      endcase
    end
    // Registered so the pin never glitches
    st_d.irq = |(flag_vec & st_q.en); // RULE_17
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.en <= RESET_VAL;
      st_q.rdata <= RESET_VAL;
      st_q.irq <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  assign rdata_out = st_q.rdata;
  assign irq_out = st_q.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_enset_sets: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr_set |=> st_q.en ==
      ($past(st_q.en) | ($past(wdata_in) & IMPL_MASK))) // RULE_01
    else $error("enable-set write did not merge ones");

  a_shared_bank: assert property (@(posedge clk_in) disable iff (!rst_n)
    (rd_in && (addr_in == OFF_EN_CLR) && !wr_in) |=>
      rdata_out == $past(st_q.en)) // RULE_02
    else $error("clear view does not show the shared bank");

  a_enclr_wrap: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_clr && wdata_in[BIT_WRAP]) |=> !st_q.en[BIT_WRAP]) // RULE_03
    else $error("wrap enable not cleared");

  a_fault_enable: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_set && (&wdata_in[BIT_UFAULT1:BIT_DEBUG])) |=>
      (&st_q.en[BIT_UFAULT1:BIT_DEBUG])) // RULE_04
    else $error("fault enables not set");

  a_zero_keeps: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_set && wdata_in[3:0] == 4'h0) |=>
      st_q.en[3:0] == $past(st_q.en[3:0])) // RULE_05
    else $error("zero write changed an enable");

  a_rsvd_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
    (rdata_out & ~IMPL_MASK) == 32'h0) // RULE_06
    else $error("reserved bits read non-zero");

  a_read_clears: assert property (@(posedge clk_in) disable iff (!rst_n)
    (value_read_in[0] && capture_mode_in[0] && !set_vec[CH_LSB]) |=>
      !flag_vec[CH_LSB]) // RULE_09
    else $error("capture read did not clear flag");

  a_w1c_chan: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_flags && wdata_in[CH_LSB] && !set_vec[CH_LSB]) |=>
      !flag_vec[CH_LSB]) // RULE_10
    else $error("write one did not clear channel flag");

  a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n)
    ##1 irq_out == $past(|(flag_vec & st_q.en))) // RULE_17
    else $error("interrupt does not follow enabled flags");

  a_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n)
    (|set_vec) |=>
      ((flag_vec & $past(set_vec)) == $past(set_vec))) // RULE_18
    else $error("set lost against clear");

endmodule : tif_irq_top

// >>> testbench/test_timer_irq_enable_flags.sv
module test_timer_irq_enable_flags
  import tif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals and block under test
  // ---------------------------------------------------------------
  logic clk_in;
  logic rst_n_in;
  logic [ADDR_W-1:0] addr_in;
  logic [31:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [31:0] rdata_out;
  logic cnt_tick_in;
  logic irq_out;
  // Event inputs laid out like the flag register
  logic [31:0] ev_q;
  logic [3:0] cap_q;
  logic [3:0] mode_q;
  logic [3:0] vrd_q;
  logic [31:0] rd_v;
  int fails;
  int cmp_count;

  tif_irq_top u_dut
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .cnt_tick_in(cnt_tick_in),
    .match_in(ev_q[19:16]),
    .capture_in(cap_q),
    .capture_mode_in(mode_q),
    .value_read_in(vrd_q),
    .ufault1_in(ev_q[15]),
    .ufault0_in(ev_q[14]),
    .rfault_b_in(ev_q[13]),
    .rfault_a_in(ev_q[12]),
    .debug_fault_in(ev_q[11]),
    .counter_event_in(ev_q[2]),
    .restart_event_in(ev_q[1]),
    .wrap_event_in(ev_q[0]),
    .irq_out(irq_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------
  // Bus, event and compare tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected read at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : chk_reg

  task automatic chk_irq(input logic exp);
    cmp_count++;
    if (irq_out !== exp)
    begin
      fails++;
      $display("unexpected irq at %0t: exp %h got %h", $time, exp, irq_out);
    end
  endtask : chk_irq

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : reg_wr

  // Read data stand one cycle only, so sample just after the edge
  task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    rd_v = rdata_out;
    chk_reg(exp, rd_v);
  endtask : read_chk

  task automatic tick;
    @(posedge clk_in);
    cnt_tick_in <= 1'b1;
    @(posedge clk_in);
    cnt_tick_in <= 1'b0;
  endtask : tick

  task automatic fire(input logic [31:0] bits);
    @(posedge clk_in);
    ev_q <= bits;
    @(posedge clk_in);
    ev_q <= '0;
  endtask : fire

  task automatic capt;
    @(posedge clk_in);
    cap_q <= 4'h1;
    @(posedge clk_in);
    cap_q <= 4'h0;
    tick;
  endtask : capt

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    read_chk(OFF_EN_CLR, RESET_VAL);
    read_chk(OFF_EN_SET, RESET_VAL);
    read_chk(OFF_FLAGS, RESET_VAL);
    chk_irq(1'b0);
  endtask : t_reset

  task automatic t_enables;
    reg_wr(8'h30, IMPL_MASK);
    read_chk(8'h30, 32'h0);
    read_chk(OFF_EN_SET, 32'h0);
    reg_wr(OFF_EN_SET, 32'h0005_0005);
    reg_wr(OFF_EN_SET, 32'h000a_a000);
    read_chk(OFF_EN_SET, 32'h000f_a005);
    reg_wr(OFF_EN_SET, 32'h0000_580a);
    read_chk(OFF_EN_CLR, IMPL_MASK);
    reg_wr(OFF_EN_CLR, 32'h0000_0001);
    reg_wr(OFF_EN_CLR, 32'h0000_0000);
    read_chk(OFF_EN_SET, 32'h000f_f80e);
    reg_wr(OFF_EN_CLR, 32'h000f_f80e);
    read_chk(OFF_EN_SET, 32'h0);
  endtask : t_enables

  // Every event flag but the capture error: pending until a tick, then sticky until written
  task automatic t_flags;
    reg_wr(OFF_EN_SET, IMPL_MASK);
    for (int b = 0; b < 20; b++)
    begin
      if (IMPL_MASK[b] && b != BIT_CAP_ERR)
      begin
        fire(32'h1 << b);
        read_chk(OFF_FLAGS, 32'h0);
        tick;
        read_chk(OFF_FLAGS, 32'h1 << b);
        chk_irq(1'b1);
        reg_wr(OFF_FLAGS, ~(32'h1 << b) & IMPL_MASK);
        read_chk(OFF_FLAGS, 32'h1 << b);
        reg_wr(OFF_FLAGS, 32'h1 << b);
        read_chk(OFF_FLAGS, 32'h0);
        chk_irq(1'b0);
      end
    end
  endtask : t_flags

  task automatic t_mask;
    reg_wr(OFF_EN_CLR, IMPL_MASK);
    fire(32'h1);
    tick;
    read_chk(OFF_FLAGS, 32'h1);
    chk_irq(1'b0);
    reg_wr(OFF_EN_SET, 32'h1);
    @(posedge clk_in);
    #1;
    chk_irq(1'b1);
    reg_wr(OFF_FLAGS, 32'h1);
    @(posedge clk_in);
    #1;
    chk_irq(1'b0);
  endtask : t_mask

  task automatic t_capture;
    capt;
    read_chk(OFF_FLAGS, 32'h0001_0000);
    // Outside capture mode a value read leaves the flag alone
    @(posedge clk_in);
    vrd_q <= 4'h1;
    @(posedge clk_in);
    vrd_q <= 4'h0;
    mode_q <= 4'h1;
    read_chk(OFF_FLAGS, 32'h0001_0000);
    capt;
    read_chk(OFF_FLAGS, 32'h0001_0008);
    @(posedge clk_in);
    vrd_q <= 4'h1;
    @(posedge clk_in);
    vrd_q <= 4'h0;
    read_chk(OFF_FLAGS, 32'h0000_0008);
    reg_wr(OFF_FLAGS, 32'h0000_0008);
    read_chk(OFF_FLAGS, 32'h0);
  endtask : t_capture

  // Clear lands on the very edge that sets the flag
  task automatic t_race;
    fire(32'h1);
    @(posedge clk_in);
    cnt_tick_in <= 1'b1;
    addr_in <= OFF_FLAGS;
    wdata_in <= 32'h1;
    wr_in <= 1'b1;
    @(posedge clk_in);
    cnt_tick_in <= 1'b0;
    wr_in <= 1'b0;
    read_chk(OFF_FLAGS, 32'h1);
    reg_wr(OFF_FLAGS, 32'h1);
  endtask : t_race

  task automatic t_rereset;
    reg_wr(OFF_EN_SET, IMPL_MASK);
    fire(32'h1);
    tick;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk_irq(1'b0);
    repeat (3) @(posedge clk_in);
    read_chk(OFF_EN_SET, RESET_VAL);
    read_chk(OFF_FLAGS, RESET_VAL);
  endtask : t_rereset

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    addr_in = '0;
    wdata_in = '0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    cnt_tick_in = 1'b0;
    ev_q = '0;
    cap_q = '0;
    mode_q = '0;
    vrd_q = '0;
    fails = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset;
    t_enables;
    t_flags;
    t_mask;
    t_capture;
    t_race;
    t_rereset;
    end_of_test;
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    fails++;
    end_of_test;
  end

endmodule : test_timer_irq_enable_flags
